// ### common/pmw_pkg.sv
// Purpose: Shared constants and types for the power-mode and wake control.
// Assumes: 100 MHz clock, 16-bit control registers on a plain register port.
// Notes: Timing counts are derived from the printed times and the clock.
// Functional notes
// - Continuous mode repeats voltage and current measurement while Active.
// - Otherwise measure only when single_trigger is written as one.
// - Intermittent wake delay codes select 20, 40, 80 or 160 ms.
// - intermittent_select picks none, serial-idle, timed or current-check mode.
// - Load pin wakes from Sleep when load_wake_from_sleep is set.
// - Charger pin wakes from Sleep when charger_wake_from_sleep is set.
// - Load pin wakes from standby or low-power when enabled.
// - Charger pin wakes from standby or low-power when enabled.
// - Auto mode checks sense current after 10, 20, 40 or 80 ms.
// - Request bits enter Standby, low-power, Sleep or Shutdown.
// - Writing zero to soft_reset_n returns all registers to defaults.
// - soft_reset_n returns to one by itself after the reset.
// - Enabled watchdog warning rising edge sets its flag.
// - Enabled current detection in auto mode sets its flag.
// - Enabled current release in auto mode sets its flag.
// - Enabled load pin edges set load-low and load-high flags.
// - Enabled charger pin edges set charger-low and charger-high flags.
// - Sleep entry clears both FET requests when fet_clear_on_sleep is set.
// - External regulator is on while ext_regulator_on is one.
// - External regulator low-power choice per standby, sleep, intermittent.
// - Internal supply low-power choice per standby, sleep, intermittent.
`default_nettype none
package pmw_pkg;
	localparam int ADDR_W = 7;
	localparam int TW = 28;
	localparam logic [ADDR_W-1:0] ADDR_PWR = 7'h01;
	localparam logic [ADDR_W-1:0] ADDR_IEN = 7'h02;
	// Field positions of power_mode_control.
	localparam int B_CONT = 15;
	localparam int B_IWD = 13;
	localparam int B_ISEL = 11;
	localparam int B_LSLP = 10;
	localparam int B_CSLP = 9;
	localparam int B_LSTB = 8;
	localparam int B_CSTB = 7;
	localparam int B_CCD = 5;
	localparam int B_STB = 4;
	localparam int B_LP = 3;
	localparam int B_SLP = 2;
	localparam int B_SHDN = 1;
	localparam int B_SRST = 0;
	// Field positions of interrupt_and_regulator_enable.
	localparam int B_WDE = 15;
	localparam int B_CDE = 14;
	localparam int B_CRE = 13;
	localparam int B_LDE = 12;
	localparam int B_CHE = 11;
	localparam int B_FCLR = 10;
	localparam int B_EXTON = 8;
	localparam int B_XSTB = 6;
	localparam int B_XSLP = 5;
	localparam int B_XINT = 4;
	localparam int B_VSTB = 3;
	localparam int B_VSLP = 2;
	localparam int B_VINT = 1;
	localparam logic [15:0] PWR_RST = 16'h0781;
	localparam logic [15:0] IEN_RST = 16'h0500;
	localparam logic [15:0] IEN_WMASK = 16'hfd7f;
	localparam logic [1:0] ISEL_NONE = 2'h0;
	localparam logic [1:0] ISEL_IDLE = 2'h1;
	localparam logic [1:0] ISEL_TIMED = 2'h2;
	localparam logic [1:0] ISEL_AUTO = 2'h3;
	// Flag indices.
	localparam int F_WDT = 0;
	localparam int F_CDET = 1;
	localparam int F_CREL = 2;
	localparam int F_LLO = 3;
	localparam int F_LHI = 4;
	localparam int F_CLO = 5;
	localparam int F_CHI = 6;
	localparam int NFLAG = 7;
	// Times and their cycle counts.
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_WAKE_MIN_MS = 20;
	localparam int T_CHECK_MIN_MS = 10;
	localparam int T_IDLE_S = 1;
	localparam int CYC_WAKE_MIN = T_WAKE_MIN_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CYC_CHECK_MIN = T_CHECK_MIN_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CYC_IDLE = T_IDLE_S * 1000000000 / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		MD_ACTIVE, MD_LOWPOWER, MD_STANDBY, MD_SLEEP, MD_SHUTDOWN, MD_CHECK
	} pmw_mode_t;
	typedef struct packed {
		logic [TW-1:0] cnt;
		logic busy;
		logic done;
	} pmw_tmr_t;
	typedef struct packed {
		logic [15:0] pwr;
		logic [15:0] ien;
		logic [15:0] rdata;
		pmw_mode_t mode;
		pmw_mode_t ret_mode;
		logic ld_q;
		logic ch_q;
		logic wdt_q;
		logic cur_q;
		logic [TW-1:0] idle_cnt;
		logic idle;
		logic meas_busy;
		logic meas_start;
		logic fet_clr;
		logic soft_rst;
		logic [NFLAG-1:0] flags;
		logic ext_on;
		logic ext_lp;
		logic vdd_lp;
	} pmw_state_t;
endpackage
`default_nettype wire

// ### hdl/pmw_timer.sv
// Purpose: One-shot down counter for the intermittent wake delays.
// Assumes: Load is a one-cycle pulse; a load while busy restarts the count.
// Notes: Done is a one-cycle pulse when the count expires.
`default_nettype none
module pmw_timer
	import pmw_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Control.
	input wire logic load,
	input wire logic [TW-1:0] load_val,
	input wire logic stop,
	// Status.
	output logic busy,
	output logic done
);
	pmw_tmr_t st_ff;
	pmw_tmr_t nxt_st;

	// Count down and flag expiry.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (stop) begin
			nxt_st.busy = 1'b0;
		end else if (load) begin
			nxt_st.cnt = load_val;
			nxt_st.busy = 1'b1;
		end else if (st_ff.busy) begin
			if (st_ff.cnt <= TW'(1)) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt - TW'(1);
			end
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign busy = st_ff.busy;
	assign done = st_ff.done;
endmodule
`default_nettype wire

// ### hdl/pmw_ctrl.sv
// Purpose: Power-mode and wake control with its two control registers.
// Assumes: Register port strobes are one-cycle pulses, inputs synchronous.
// Notes: Hardware clears the mode requests when a wake event is taken.
`default_nettype none
module pmw_ctrl
	import pmw_pkg::*;
#(
	parameter int WAKE_BASE_CYC = CYC_WAKE_MIN,
	parameter int CHECK_BASE_CYC = CYC_CHECK_MIN,
	parameter int IDLE_CYC = CYC_IDLE
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register port.
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Detect pins and events.
	input wire logic load_detect_pin,
	input wire logic charger_detect_pin,
	input wire logic watchdog_warning_trigger,
	input wire logic sense_current_high,
	input wire logic serial_activity,
	// Measurement handshake.
	input wire logic single_trigger,
	input wire logic measure_done,
	output logic measure_start,
	// Status flags.
	input wire logic [NFLAG-1:0] flag_clear,
	output logic [NFLAG-1:0] flag_status,
	// Power control outputs.
	output pmw_mode_t mode_state,
	output logic fet_clear,
	output logic soft_reset_pulse,
	output logic ext_regulator_en,
	output logic ext_reg_lowpower,
	output logic int_supply_lowpower
);
	localparam pmw_state_t ST_RST = '{
		pwr: PWR_RST, ien: IEN_RST, rdata: 16'h0000,
		mode: MD_ACTIVE, ret_mode: MD_ACTIVE,
		ld_q: 1'b0, ch_q: 1'b0, wdt_q: 1'b0, cur_q: 1'b0,
		idle_cnt: '0, idle: 1'b0, meas_busy: 1'b0, meas_start: 1'b0,
		fet_clr: 1'b0, soft_rst: 1'b0, flags: '0,
		ext_on: 1'b1, ext_lp: 1'b0, vdd_lp: 1'b0
	};

	pmw_state_t st_ff;
	pmw_state_t nxt_st;
	logic tmr_load;
	logic tmr_busy;
	logic tmr_done;
	logic tmr_stop;
	logic [TW-1:0] tmr_val;
	logic [1:0] isel;
	logic intm_on;
	logic low_mode;
	logic slp_wake;
	logic stb_wake;
	logic [1:0] ld_edge;
	logic [1:0] ch_edge;
	logic [NFLAG-1:0] fset;

	// Returns {rising, falling} of a pin when its flag pair is enabled.
	function automatic logic [1:0] pin_edges(input logic en,
		input logic prev, input logic cur);
		pin_edges = {en & cur & ~prev, en & prev & ~cur};
	endfunction

	// Delay timer for intermittent wake and auto current checks.
	pmw_timer u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.load(tmr_load),
		.load_val(tmr_val),
		.stop(tmr_stop),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// Wake sources, intermittent choice and timer control.
	always_comb begin
		isel = st_ff.pwr[B_ISEL +: 2];
		intm_on = (isel == ISEL_TIMED) || (isel == ISEL_AUTO) ||
			((isel == ISEL_IDLE) && st_ff.idle);
		low_mode = (st_ff.mode == MD_STANDBY) ||
			(st_ff.mode == MD_LOWPOWER);
		slp_wake = (st_ff.pwr[B_LSLP] & load_detect_pin) |
			(st_ff.pwr[B_CSLP] & charger_detect_pin);
		stb_wake = (st_ff.pwr[B_LSTB] & load_detect_pin) |
			(st_ff.pwr[B_CSTB] & charger_detect_pin);
		// Each code step doubles the base delay of the chosen mode.
		if (isel == ISEL_AUTO) begin
			tmr_val = TW'(CHECK_BASE_CYC) << st_ff.pwr[B_CCD +: 2];
		end else begin
			tmr_val = TW'(WAKE_BASE_CYC) << st_ff.pwr[B_IWD +: 2];
		end
		// Load only when idle, so an expiry pulse is not lost to a reload.
		tmr_load = low_mode && intm_on && !tmr_busy && !tmr_done;
		tmr_stop = !(low_mode && intm_on);
	end

	// Flag set terms from enabled edges and auto-mode current events.
	always_comb begin
		ld_edge = pin_edges(st_ff.ien[B_LDE], st_ff.ld_q,
			load_detect_pin);
		ch_edge = pin_edges(st_ff.ien[B_CHE], st_ff.ch_q,
			charger_detect_pin);
		fset = '0;
		fset[F_WDT] = st_ff.ien[B_WDE] & watchdog_warning_trigger &
			~st_ff.wdt_q;
		fset[F_CDET] = st_ff.ien[B_CDE] && (isel == ISEL_AUTO) &&
			low_mode && tmr_done && sense_current_high;
		fset[F_CREL] = st_ff.ien[B_CRE] && (isel == ISEL_AUTO) &&
			st_ff.cur_q && !sense_current_high;
		fset[F_LHI] = ld_edge[1];
		fset[F_LLO] = ld_edge[0];
		fset[F_CHI] = ch_edge[1];
		fset[F_CLO] = ch_edge[0];
	end

	// Next-state logic for registers, mode and outputs.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.meas_start = 1'b0;
		nxt_st.fet_clr = 1'b0;
		nxt_st.soft_rst = 1'b0;
		nxt_st.ld_q = load_detect_pin;
		nxt_st.ch_q = charger_detect_pin;
		nxt_st.wdt_q = watchdog_warning_trigger;
		nxt_st.cur_q = sense_current_high;

		// Serial idle detector for the idle-based intermittent choice.
		if (serial_activity) begin
			nxt_st.idle_cnt = '0;
			nxt_st.idle = 1'b0;
		end else if (st_ff.idle_cnt >= TW'(IDLE_CYC)) begin
			nxt_st.idle = 1'b1;
		end else begin
			nxt_st.idle_cnt = st_ff.idle_cnt + TW'(1);
		end

		// A set arriving with its clear keeps the flag set.
		for (int i = 0; i < NFLAG; i++) begin
			nxt_st.flags[i] = fset[i] | (st_ff.flags[i] & ~flag_clear[i]);
		end

		// Measurement busy ends when the converter reports done.
		if (measure_done) begin
			nxt_st.meas_busy = 1'b0;
		end

		// Mode sequencing.
		case (st_ff.mode)
			// Requests are taken by priority, shutdown first.
			MD_ACTIVE: begin
				if (st_ff.pwr[B_SHDN]) begin
					nxt_st.mode = MD_SHUTDOWN;
				end else if (st_ff.pwr[B_SLP]) begin
					nxt_st.mode = MD_SLEEP;
					nxt_st.fet_clr = st_ff.ien[B_FCLR];
				end else if (st_ff.pwr[B_STB]) begin
					nxt_st.mode = MD_STANDBY;
				end else if (st_ff.pwr[B_LP]) begin
					nxt_st.mode = MD_LOWPOWER;
				end else if (!st_ff.meas_busy && (st_ff.pwr[B_CONT] ||
					single_trigger)) begin
					nxt_st.meas_start = 1'b1;
					nxt_st.meas_busy = 1'b1;
				end
			end
			// A pin wake clears the low-mode requests so Active sticks.
			// An expired timer measures, or in auto mode tests current.
			MD_STANDBY, MD_LOWPOWER: begin
				if (st_ff.pwr[B_SHDN]) begin
					nxt_st.mode = MD_SHUTDOWN;
				end else if (st_ff.pwr[B_SLP]) begin
					nxt_st.mode = MD_SLEEP;
					nxt_st.fet_clr = st_ff.ien[B_FCLR];
				end else if (stb_wake) begin
					nxt_st.mode = MD_ACTIVE;
					nxt_st.pwr[B_STB] = 1'b0;
					nxt_st.pwr[B_LP] = 1'b0;
				end else if (!st_ff.pwr[B_STB] && !st_ff.pwr[B_LP]) begin
					nxt_st.mode = MD_ACTIVE;
				end else if (tmr_done && intm_on) begin
					if (isel != ISEL_AUTO) begin
						nxt_st.mode = MD_CHECK;
						nxt_st.ret_mode = st_ff.mode;
						nxt_st.meas_start = 1'b1;
						nxt_st.meas_busy = 1'b1;
					end else if (sense_current_high) begin
						nxt_st.mode = MD_ACTIVE;
						nxt_st.pwr[B_STB] = 1'b0;
						nxt_st.pwr[B_LP] = 1'b0;
					end
				end
			end
			// A check ends on done or when no measurement is pending.
			MD_CHECK: begin
				if (stb_wake) begin
					nxt_st.mode = MD_ACTIVE;
					nxt_st.pwr[B_STB] = 1'b0;
					nxt_st.pwr[B_LP] = 1'b0;
				end else if (!st_ff.meas_busy || measure_done) begin
					nxt_st.mode = st_ff.ret_mode;
				end
			end
			// Sleep ends on an enabled pin level or a dropped request.
			MD_SLEEP: begin
				if (st_ff.pwr[B_SHDN]) begin
					nxt_st.mode = MD_SHUTDOWN;
				end else if (slp_wake) begin
					nxt_st.mode = MD_ACTIVE;
					nxt_st.pwr[B_SLP] = 1'b0;
				end else if (!st_ff.pwr[B_SLP]) begin
					nxt_st.mode = MD_ACTIVE;
				end
			end
			// Only a reset or a soft reset write leaves shutdown.
			MD_SHUTDOWN: begin
				nxt_st.mode = MD_SHUTDOWN;
			end
			// Unused encodings fall back to Active.
			default: begin
				nxt_st.mode = MD_ACTIVE;
			end
		endcase

		// Host writes take effect after hardware request clearing.
		if (reg_wr && (reg_addr == ADDR_PWR)) begin
			nxt_st.pwr = reg_wdata;
			nxt_st.pwr[B_SRST] = 1'b1;
			if (!reg_wdata[B_SRST]) begin
				nxt_st.pwr = PWR_RST;
				nxt_st.ien = IEN_RST;
				nxt_st.mode = MD_ACTIVE;
				nxt_st.soft_rst = 1'b1;
				// Status and sequencing state go back to defaults as well,
				// so no stale flag or pending pulse outlives the reset.
				nxt_st.flags = '0;
				nxt_st.ret_mode = MD_ACTIVE;
				nxt_st.meas_busy = 1'b0;
				nxt_st.meas_start = 1'b0;
				nxt_st.fet_clr = 1'b0;
			end
		end else if (reg_wr && (reg_addr == ADDR_IEN)) begin
			nxt_st.ien = reg_wdata & IEN_WMASK;
		end

		// Register read data, unmapped addresses read as zero.
		if (reg_rd) begin
			case (reg_addr)
				ADDR_PWR: nxt_st.rdata = st_ff.pwr;
				ADDR_IEN: nxt_st.rdata = st_ff.ien;
				default: nxt_st.rdata = 16'h0000;
			endcase
		end

		// Regulator enable follows its bit; low-power controls follow the current mode.
		nxt_st.ext_on = st_ff.ien[B_EXTON];
		nxt_st.ext_lp = 1'b0;
		nxt_st.vdd_lp = 1'b0;
		// Sleep has its own selects; intermittent selects beat standby.
		if (st_ff.mode == MD_SLEEP) begin
			nxt_st.ext_lp = st_ff.ien[B_XSLP];
			nxt_st.vdd_lp = st_ff.ien[B_VSLP];
		end else if ((low_mode || (st_ff.mode == MD_CHECK)) && intm_on)
		begin
			nxt_st.ext_lp = st_ff.ien[B_XINT];
			nxt_st.vdd_lp = st_ff.ien[B_VINT];
		end else if (low_mode) begin
			nxt_st.ext_lp = st_ff.ien[B_XSTB];
			nxt_st.vdd_lp = st_ff.ien[B_VSTB];
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register.
	assign reg_rdata = st_ff.rdata;
	assign measure_start = st_ff.meas_start;
	assign flag_status = st_ff.flags;
	assign mode_state = st_ff.mode;
	assign fet_clear = st_ff.fet_clr;
	assign soft_reset_pulse = st_ff.soft_rst;
	assign ext_regulator_en = st_ff.ext_on;
	assign ext_reg_lowpower = st_ff.ext_lp;
	assign int_supply_lowpower = st_ff.vdd_lp;
endmodule
`default_nettype wire

// ### dv/pmw_ctrl_asserts.sv
// Purpose: Port-level checks of the power-mode and wake control.
// Assumes: Single clock domain, synchronous active-low reset.
// Notes: Attached to every pmw_ctrl instance through the bind below.
`default_nettype none
module pmw_ctrl_asserts
	import pmw_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// Register port.
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Status and power outputs.
	input wire logic [NFLAG-1:0] flag_clear,
	input wire logic [NFLAG-1:0] flag_status,
	input wire pmw_mode_t mode_state,
	input wire logic fet_clear,
	input wire logic soft_reset_pulse,
	input wire logic ext_regulator_en,
	input wire logic measure_start
);
	// All checks share the one clock and reset.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	ext_reg_follow_a: assert property (reg_wr && reg_addr == ADDR_IEN |-> ##2
		ext_regulator_en == $past(reg_wdata[B_EXTON], 2))
		else $error("external regulator enable does not follow the write");
	soft_reset_a: assert property (reg_wr && reg_addr == ADDR_PWR &&
		!reg_wdata[B_SRST] |=> soft_reset_pulse && mode_state == MD_ACTIVE)
		else $error("soft reset write not taken");
	reset_bit_set_a: assert property (reg_rd && reg_addr == ADDR_PWR |=>
		reg_rdata[B_SRST])
		else $error("soft reset bit reads as zero");
	unmapped_zero_a: assert property (reg_rd && reg_addr != ADDR_PWR &&
		reg_addr != ADDR_IEN |=> reg_rdata == 16'h0000)
		else $error("unmapped read is not zero");
	reserved_zero_a: assert property (reg_rd && reg_addr == ADDR_IEN |=>
		!reg_rdata[9] && !reg_rdata[7])
		else $error("read-only enable bits read as one");
	fet_clear_sleep_a: assert property (fet_clear |-> mode_state == MD_SLEEP
		&& $past(mode_state) != MD_SLEEP)
		else $error("FET clear outside sleep entry");
	shutdown_hold_a: assert property (mode_state == MD_SHUTDOWN && !reg_wr &&
		!$past(reg_wr) |=> mode_state == MD_SHUTDOWN)
		else $error("shutdown left without reset");
	flag_sticky_a: assert property (flag_status[F_LHI] && !flag_clear[F_LHI]
		&& !reg_wr |=> $stable(flag_status[F_LHI]))
		else $error("load high flag lost without clear");
	start_pulse_a: assert property (measure_start |=> !measure_start)
		else $error("measurement start longer than one cycle");
endmodule
bind pmw_ctrl pmw_ctrl_asserts chk_u (.clk(clk), .rst_b(rst_b),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .flag_clear(flag_clear),
	.flag_status(flag_status), .mode_state(mode_state),
	.fet_clear(fet_clear), .soft_reset_pulse(soft_reset_pulse),
	.ext_regulator_en(ext_regulator_en), .measure_start(measure_start));
`default_nettype wire

// ### dv/pmw_host.sv
// Purpose: Host model that writes and reads the two control registers.
// Assumes: One access at a time, launched just after a rising edge.
// Notes: Idle address and data show the inverse of the last value.
`default_nettype none
module pmw_host
	import pmw_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Register port.
	output logic [ADDR_W-1:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// Port is quiet at time zero.
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Write one word; callers put at most one mode request in it.
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= (a == ADDR_IEN) ? {d[15:1], 1'b0} : d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// Read one word; data is settled one cycle after the strobe edge.
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] q);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		q = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ### dv/pmw_ctrl_bench.sv
// Purpose: Self-checking bench of the power-mode and wake control.
// Assumes: Short timer parameters so intermittent waits stay brief.
// Notes: Pins change by non-blocking assignment at rising edges.
`default_nettype none
module pmw_ctrl_bench
	import pmw_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, reg_wr, reg_rd, ld, ch, wdt, cur, trig, mdone, sact;
	logic fet_clr, srst, ext_en, ext_lp, vdd_lp, mstart;
	logic [ADDR_W-1:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, q;
	logic [NFLAG-1:0] fclr, flags;
	pmw_mode_t mode;
	int err_total, checked, n, i;

	// Design with shortened wake, check and idle counts.
	pmw_ctrl #(.WAKE_BASE_CYC(8), .CHECK_BASE_CYC(4), .IDLE_CYC(16)) dut_u (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.load_detect_pin(ld), .charger_detect_pin(ch),
		.watchdog_warning_trigger(wdt), .sense_current_high(cur),
		.serial_activity(sact), .single_trigger(trig), .measure_done(mdone),
		.measure_start(mstart), .flag_clear(fclr), .flag_status(flags),
		.mode_state(mode), .fet_clear(fet_clr), .soft_reset_pulse(srst),
		.ext_regulator_en(ext_en), .ext_reg_lowpower(ext_lp),
		.int_supply_lowpower(vdd_lp));
	pmw_host host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// Clock of 10 ns period.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compare one result and count it.
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Read a register and compare it.
	task automatic rdc(input logic [ADDR_W-1:0] a, input logic [15:0] e);
		host_u.rd(a, q);
		cmp(q, e);
	endtask

	// Wait a bounded time for a mode, leaving the cycle count in n.
	task automatic waitm(input pmw_mode_t m, input int lim);
		#1;
		n = 0;
		while (mode !== m && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp(16'(mode), 16'(m));
	endtask

	// Clear all sticky flags.
	task automatic clrf();
		@(posedge clk) fclr <= '1;
		@(posedge clk) fclr <= '0;
	endtask

	// Print counts and the verdict, then stop.
	task automatic tally_and_finish();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Cut a hang short.
	initial begin
		#60000;
		err_total++;
		tally_and_finish();
	end

	// Test sequence.
	initial begin
		{rst_b, ld, ch, wdt, cur, trig, mdone} = '0;
		sact = 1'b1;
		fclr = '0;
		err_total = 0;
		checked = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rdc(ADDR_PWR, 16'h0781);
		rdc(ADDR_IEN, 16'h0500);
		rdc(7'h05, 16'h0000);
		cmp(16'(ext_en), 16'h0001);
		$display("test 1 done");
		host_u.wr(ADDR_IEN, 16'hffff);
		rdc(ADDR_IEN, 16'hfd7e);
		host_u.wr(ADDR_IEN, 16'hfd24);
		host_u.wr(ADDR_IEN, 16'hfc24);
		@(posedge clk);
		#1 cmp(16'(ext_en), 16'h0000);
		host_u.wr(ADDR_IEN, 16'hfd24);
		$display("test 2 done");
		host_u.wr(ADDR_PWR, 16'h0785);
		waitm(MD_SLEEP, 4);
		cmp(16'(fet_clr), 16'h0001);
		@(posedge clk) ld <= 1'b1;
		#1 cmp(16'({ext_lp, vdd_lp}), 16'h0003);
		waitm(MD_ACTIVE, 4);
		@(posedge clk);
		#1 cmp(16'(flags), 16'h0010);
		rdc(ADDR_PWR, 16'h0781);
		clrf();
		@(posedge clk) ld <= 1'b0;
		repeat (3) @(posedge clk);
		#1 cmp(16'(flags), 16'h0008);
		clrf();
		$display("test 3 done");
		host_u.wr(ADDR_PWR, 16'h0385);
		waitm(MD_SLEEP, 4);
		@(posedge clk) ld <= 1'b1;
		repeat (6) @(posedge clk);
		#1 cmp(16'(mode), 16'(MD_SLEEP));
		@(posedge clk) ch <= 1'b1;
		waitm(MD_ACTIVE, 4);
		@(posedge clk);
		#1 cmp(16'(flags), 16'h0050);
		@(posedge clk) {ld, ch} <= 2'b00;
		$display("test 4 done");
		for (i = 0; i < 2; i++) begin
			host_u.wr(ADDR_PWR, i ? 16'h0789 : 16'h0791);
			waitm(i ? MD_LOWPOWER : MD_STANDBY, 4);
			@(posedge clk);
			#1 cmp(16'({ext_lp, vdd_lp}), 16'h0000);
			@(posedge clk) {ch, ld} <= i ? 2'b10 : 2'b01;
			waitm(MD_ACTIVE, 4);
			@(posedge clk) {ld, ch} <= 2'b00;
		end
		$display("test 5 done");
		host_u.wr(ADDR_PWR, 16'h0783);
		waitm(MD_SHUTDOWN, 4);
		@(posedge clk) {ld, ch} <= 2'b11;
		repeat (5) @(posedge clk);
		#1 cmp(16'(mode), 16'(MD_SHUTDOWN));
		host_u.wr(ADDR_PWR, 16'h0780);
		#1 cmp(16'(srst), 16'h0001);
		cmp(16'(flags), 16'h0000);
		rdc(ADDR_PWR, 16'h0781);
		rdc(ADDR_IEN, 16'h0500);
		@(posedge clk) {ld, ch} <= 2'b00;
		clrf();
		$display("test 6 done");
		@(posedge clk) trig <= 1'b1;
		@(posedge clk) trig <= 1'b0;
		#1 cmp(16'(mstart), 16'h0001);
		@(posedge clk) mdone <= 1'b1;
		@(posedge clk) mdone <= 1'b0;
		n = 0;
		repeat (8) @(posedge clk) n += mstart;
		cmp(16'(n), 16'h0000);
		host_u.wr(ADDR_PWR, 16'h8781);
		n = 0;
		repeat (40) begin
			@(posedge clk);
			mdone <= mstart;
			n += mstart;
		end
		cmp(16'(n >= 3), 16'h0001);
		host_u.wr(ADDR_PWR, 16'h0781);
		repeat (4) @(posedge clk) mdone <= mstart;
		$display("test 7 done");
		host_u.wr(ADDR_IEN, 16'h0512);
		host_u.wr(ADDR_PWR, 16'h3791);
		waitm(MD_STANDBY, 4);
		@(posedge clk);
		#1 cmp(16'({ext_lp, vdd_lp}), 16'h0003);
		waitm(MD_CHECK, 30);
		cmp(16'(n >= 14 && n <= 18), 16'h0001);
		@(posedge clk) mdone <= 1'b1;
		@(posedge clk) mdone <= 1'b0;
		waitm(MD_STANDBY, 4);
		host_u.wr(ADDR_PWR, 16'h0781);
		waitm(MD_ACTIVE, 4);
		$display("test 8 done");
		host_u.wr(ADDR_IEN, 16'he500);
		@(posedge clk) cur <= 1'b1;
		host_u.wr(ADDR_PWR, 16'h1f91);
		waitm(MD_STANDBY, 4);
		waitm(MD_ACTIVE, 12);
		@(posedge clk) {wdt, cur} <= 2'b10;
		repeat (3) @(posedge clk);
		#1 cmp(16'(flags), 16'h0007);
		$display("test 9 done");
		host_u.wr(ADDR_IEN, 16'h0000);
		host_u.wr(ADDR_PWR, 16'h0f91);
		repeat (30) @(posedge clk);
		#1 cmp(16'(mode), 16'(MD_STANDBY));
		@(posedge clk) sact <= 1'b0;
		waitm(MD_CHECK, 40);
		cmp(16'(n >= 24 && n <= 30), 16'h0001);
		@(posedge clk) mdone <= 1'b1;
		@(posedge clk) mdone <= 1'b0;
		waitm(MD_STANDBY, 4);
		$display("test 10 done");
		@(posedge clk) rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1 cmp(16'(mode), 16'(MD_ACTIVE));
		cmp(16'(flags), 16'h0000);
		cmp(16'(ext_en), 16'h0001);
		rdc(ADDR_PWR, 16'h0781);
		$display("test 11 done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
